// [rtl/ppfm_edge_det.sv]
`timescale 1ns/100ps
module ppfm_edge_det (
   // Clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic int_rst_i,
   // Edge channel
   ppfm_edge_if.det eif
);
   logic prev_q;
   logic prev_d;
   logic edge_q;
   logic edge_d;

   // Edge taken on the gated level, so mode changes count as edges
   always_comb begin
      prev_d = eif.level;
      edge_d = (eif.rise_en & eif.level & ~prev_q)
             | (eif.fall_en & ~eif.level & prev_q); // R4 R5
      if (int_rst_i) begin
         prev_d = 1'b0;
         edge_d = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_q <= 1'b0;
         edge_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
         edge_q <= edge_d;
      end
   end

   assign eif.edge_det = edge_q;
endmodule : ppfm_edge_det

// [rtl/ppfm_edge_if.sv]
`timescale 1ns/100ps
interface ppfm_edge_if;
   logic level;
   logic rise_en;
   logic fall_en;
   logic edge_det;
   modport det (input level, input rise_en, input fall_en, output edge_det);
   modport src (output level, output rise_en, output fall_en, input edge_det);
endinterface : ppfm_edge_if

// [rtl/ppfm_pkg.sv]
package ppfm_pkg;
   localparam int unsigned PORT_W = 8;
   localparam int unsigned ADDR_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_DIR = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_FSEL = 8'h0C;
   localparam logic [7:0] OFS_ODRN = 8'h10;
   localparam logic [7:0] OFS_BITOP = 8'h14;
   localparam logic [7:0] OFS_EDGE = 8'h18;
   localparam logic [7:0] OFS_DBG = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   // Reset values
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_FSEL = 8'h00;
   localparam logic [7:0] RST_ODRN = 8'h00;
   localparam logic [1:0] RST_EDGE = 2'h0;
   localparam logic RST_DBG_EN = 1'b1;
   localparam logic [1:0] RST_IRQ = 2'h0;
   // Pin positions of the shared pins
   localparam int unsigned PIN_SER = 1;
   localparam int unsigned PIN_NMI = 2;
   localparam int unsigned PIN_DBG = 5;
   // Field positions
   localparam int unsigned BITOP_SEL_LSB = 0;
   localparam int unsigned BITOP_VAL_POS = 8;
   localparam int unsigned EDGE_RISE_POS = 0;
   localparam int unsigned EDGE_FALL_POS = 1;
   localparam int unsigned DBG_EN_POS = 0;
   localparam int unsigned IRQ_NMI_POS = 0;
   localparam int unsigned IRQ_DBG_POS = 1;
   localparam logic RST_PREADY = 1'b0;
endpackage : ppfm_pkg

// [rtl/ppfm_port_mux.sv]
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// R1 - Mode bit picks port or alternate; select bit picks serial or clock
// R2 - Alternate inputs see pin level ANDed with the mode bit
// R3 - Software enables alternate operation only after setting mode bit
// R4 - Mode 0 to 1 with pin high is a rising edge
// R5 - Mode 1 to 0 with pin high is a falling edge
// R6 - Software sets interrupt edge only after switching pin function
// R7 - Open-drain bit acts only when direction selects output; in alternate mode the code applies it whatever the direction bit is
// R8 - Input bits: writes load latch, reads return pin level
// R9 - Output bits: reads return the output latch
// R10 - Single-bit operation is byte read, modify, byte write
// R11 - Software rewrites latch when turning an input into output
// R12 - External pin reset makes shared pin the debug-reset input
// R13 - High on debug-reset input enters debug mode, debug pins live
// R14 - Software clears debug enable; pin stays low until then
// R15 - Internal resets keep debug pin setup and debug register
// R16 - Pull-down on after pin reset, off when debug enable clears
// R17 - Every data write loads the output latch in any mode
// R18 - Control writes reach the pin path one cycle later
module ppfm_port_mux (
   // Clock and reset
   input wire logic clock_i,
   input wire logic arst_n_i,
   // Internal reset sources
   input wire logic wdt_rst_i,
   input wire logic clkmon_rst_i,
   input wire logic lvd_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Pins
   input wire logic [7:0] pin_i,
   output logic [7:0] pin_o,
   output logic [7:0] pin_oe_o,
   output logic dbg_pull_dn_en_o,
   // Peripheral side
   input wire logic [7:0] alt_a_out_i,
   input wire logic [7:0] alt_b_out_i,
   input wire logic [7:0] alt_oe_i,
   output logic [7:0] alt_in_o,
   output logic nmi_req_o,
   // Debug
   output logic debug_reset_in_o,
   output logic debug_pins_en_o,
   // Interrupt
   output logic irq_o
);
   logic int_rst;
   logic [7:0] data_q, data_d;
   logic [7:0] dir_q, dir_d;
   logic [7:0] mode_q, mode_d;
   logic [7:0] fsel_q, fsel_d;
   logic [7:0] odrn_q, odrn_d;
   logic [1:0] edge_q, edge_d;
   logic dbg_en_q, dbg_en_d;
   logic [1:0] irq_stat_q, irq_stat_d;
   logic [1:0] irq_mask_q, irq_mask_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [7:0] pin_out_q, pin_out_d;
   logic [7:0] pin_oe_q, pin_oe_d;
   logic [7:0] alt_in_q, alt_in_d;
   logic pull_q, pull_d;
   logic dbg_rst_q, dbg_rst_d;
   logic dbg_act_q, dbg_act_d;
   logic irq_q, irq_d;
   logic nmi_q, nmi_d;
   logic [7:0] port_rd;
   logic [7:0] bitop_val;
   logic [2:0] bit_sel;
   logic wr_acc;
   logic rd_setup;
   logic addr_ok;
   logic nmi_edge;

   ppfm_edge_if eif ();

   assign int_rst = wdt_rst_i | clkmon_rst_i | lvd_rst_i;

   // Gated level feeds the edge detector
   assign eif.level = pin_i[ppfm_pkg::PIN_NMI]
                    & mode_q[ppfm_pkg::PIN_NMI]; // R2 R4 R5
   assign eif.rise_en = edge_q[ppfm_pkg::EDGE_RISE_POS];
   assign eif.fall_en = edge_q[ppfm_pkg::EDGE_FALL_POS];
   assign nmi_edge = eif.edge_det;

   ppfm_edge_det u_edge (
      .clock_i (clock_i),
      .arst_n_i (arst_n_i),
      .int_rst_i (int_rst),
      .eif (eif)
   );

   // Port read value per bit
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_rd
         assign port_rd[g] = dir_q[g] ? pin_i[g] : data_q[g]; // R8 R9
      end
   endgenerate

   // Single-bit operation: byte read, modify one bit, byte write
   assign bit_sel = pwdata_i[ppfm_pkg::BITOP_SEL_LSB +: 3];
   always_comb begin
      bitop_val = port_rd; // R10
      bitop_val[bit_sel] = pwdata_i[ppfm_pkg::BITOP_VAL_POS]; // R10
   end

   assign wr_acc = psel_i & penable_i & pready_q & pwrite_i;
   assign rd_setup = psel_i & ~penable_i;

   always_comb begin
      unique case (paddr_i)
         ppfm_pkg::OFS_DATA, ppfm_pkg::OFS_DIR, ppfm_pkg::OFS_MODE,
         ppfm_pkg::OFS_FSEL, ppfm_pkg::OFS_ODRN, ppfm_pkg::OFS_BITOP,
         ppfm_pkg::OFS_EDGE, ppfm_pkg::OFS_DBG, ppfm_pkg::OFS_IRQ_STAT,
         ppfm_pkg::OFS_IRQ_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // Register file next state
   always_comb begin
      data_d = data_q;
      dir_d = dir_q;
      mode_d = mode_q;
      fsel_d = fsel_q;
      odrn_d = odrn_q;
      edge_d = edge_q;
      dbg_en_d = dbg_en_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      pready_d = rd_setup;
      pslverr_d = rd_setup & ~addr_ok;
      prdata_d = prdata_q;
      if (rd_setup) begin
         prdata_d = 32'h0000_0000;
         unique case (paddr_i)
            ppfm_pkg::OFS_DATA: prdata_d[7:0] = port_rd; // R8 R9
            ppfm_pkg::OFS_DIR: prdata_d[7:0] = dir_q;
            ppfm_pkg::OFS_MODE: prdata_d[7:0] = mode_q;
            ppfm_pkg::OFS_FSEL: prdata_d[7:0] = fsel_q;
            ppfm_pkg::OFS_ODRN: prdata_d[7:0] = odrn_q;
            ppfm_pkg::OFS_EDGE: prdata_d[1:0] = edge_q;
            ppfm_pkg::OFS_DBG: prdata_d[ppfm_pkg::DBG_EN_POS] = dbg_en_q;
            ppfm_pkg::OFS_IRQ_STAT: prdata_d[1:0] = irq_stat_q;
            ppfm_pkg::OFS_IRQ_MASK: prdata_d[1:0] = irq_mask_q;
            default: prdata_d = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         unique case (paddr_i)
            ppfm_pkg::OFS_DATA: data_d = pwdata_i[7:0]; // R8 R17
            ppfm_pkg::OFS_DIR: dir_d = pwdata_i[7:0];
            ppfm_pkg::OFS_MODE: mode_d = pwdata_i[7:0];
            ppfm_pkg::OFS_FSEL: fsel_d = pwdata_i[7:0];
            ppfm_pkg::OFS_ODRN: odrn_d = pwdata_i[7:0];
            ppfm_pkg::OFS_BITOP: data_d = bitop_val; // R10 R17
            ppfm_pkg::OFS_EDGE: edge_d = pwdata_i[1:0];
            ppfm_pkg::OFS_DBG:
               dbg_en_d = pwdata_i[ppfm_pkg::DBG_EN_POS];
            ppfm_pkg::OFS_IRQ_STAT: irq_stat_d = irq_stat_q & ~pwdata_i[1:0];
            ppfm_pkg::OFS_IRQ_MASK: irq_mask_d = pwdata_i[1:0];
            default: data_d = data_q;
         endcase
      end
      // Events set after the clear so a same-cycle event wins
      if (nmi_edge) begin
         irq_stat_d[ppfm_pkg::IRQ_NMI_POS] = 1'b1;
      end
      if (dbg_rst_d & ~dbg_rst_q) begin
         irq_stat_d[ppfm_pkg::IRQ_DBG_POS] = 1'b1;
      end
      // Internal resets clear port setup but not the debug register
      if (int_rst) begin
         data_d = ppfm_pkg::RST_DATA;
         dir_d = ppfm_pkg::RST_DIR;
         mode_d = ppfm_pkg::RST_MODE;
         fsel_d = ppfm_pkg::RST_FSEL;
         odrn_d = ppfm_pkg::RST_ODRN;
         edge_d = ppfm_pkg::RST_EDGE;
         irq_stat_d = ppfm_pkg::RST_IRQ;
         irq_mask_d = ppfm_pkg::RST_IRQ;
         dbg_en_d = dbg_en_q; // R15
      end
   end

   // Pin path next state, all from registered control
   always_comb begin
      pin_out_d = 8'h00;
      pin_oe_d = 8'h00;
      alt_in_d = pin_i & mode_q; // R2
      for (int i = 0; i < 8; i++) begin
         if (mode_q[i]) begin
            pin_out_d[i] = fsel_q[i] ? alt_b_out_i[i]
                                     : alt_a_out_i[i]; // R1
            pin_oe_d[i] = alt_oe_i[i]
                        & ~(odrn_q[i] & pin_out_d[i]); // R1
         end else begin
            pin_out_d[i] = data_q[i];
            pin_oe_d[i] = ~dir_q[i]
                        & ~(odrn_q[i] & data_q[i]); // R1 R7
         end
      end
      // Debug-reset input owns the shared pin while enabled
      if (dbg_en_q) begin
         pin_oe_d[ppfm_pkg::PIN_DBG] = 1'b0; // R12
         pin_out_d[ppfm_pkg::PIN_DBG] = 1'b0;
         alt_in_d[ppfm_pkg::PIN_DBG] = 1'b0;
      end
      pull_d = dbg_en_q; // R16
      dbg_rst_d = dbg_en_q & pin_i[ppfm_pkg::PIN_DBG]; // R13
      dbg_act_d = dbg_act_q | dbg_rst_d; // R13
      if (~dbg_en_q) begin
         dbg_act_d = 1'b0;
      end
      nmi_d = nmi_edge;
      irq_d = |(irq_stat_q & irq_mask_q);
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data_q <= ppfm_pkg::RST_DATA;
         dir_q <= ppfm_pkg::RST_DIR;
         mode_q <= ppfm_pkg::RST_MODE;
         fsel_q <= ppfm_pkg::RST_FSEL;
         odrn_q <= ppfm_pkg::RST_ODRN;
         edge_q <= ppfm_pkg::RST_EDGE;
         dbg_en_q <= ppfm_pkg::RST_DBG_EN; // R12
         irq_stat_q <= ppfm_pkg::RST_IRQ;
         irq_mask_q <= ppfm_pkg::RST_IRQ;
         pready_q <= ppfm_pkg::RST_PREADY;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         data_q <= data_d;
         dir_q <= dir_d;
         mode_q <= mode_d; // R18
         fsel_q <= fsel_d; // R18
         odrn_q <= odrn_d; // R18
         edge_q <= edge_d;
         dbg_en_q <= dbg_en_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_out_q <= 8'h00;
         pin_oe_q <= 8'h00;
         alt_in_q <= 8'h00;
         pull_q <= 1'b1; // R16
         dbg_rst_q <= 1'b0;
         dbg_act_q <= 1'b0;
         irq_q <= 1'b0;
         nmi_q <= 1'b0;
      end else begin
         pin_out_q <= pin_out_d;
         pin_oe_q <= pin_oe_d;
         alt_in_q <= alt_in_d;
         pull_q <= pull_d;
         dbg_rst_q <= dbg_rst_d;
         dbg_act_q <= dbg_act_d;
         irq_q <= irq_d;
         nmi_q <= nmi_d;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign pin_o = pin_out_q;
   assign pin_oe_o = pin_oe_q;
   assign alt_in_o = alt_in_q;
   assign dbg_pull_dn_en_o = pull_q;
   assign debug_reset_in_o = dbg_rst_q;
   assign debug_pins_en_o = dbg_act_q;
   assign irq_o = irq_q;
   assign nmi_req_o = nmi_q;
endmodule : ppfm_port_mux

// [sim/ppfm_pin_model.sv]
`timescale 1ns/100ps
module ppfm_pin_model (
   // Clock
   input wire logic clock_i,
   // Design drive
   input wire logic [7:0] pin_o_i,
   input wire logic [7:0] pin_oe_i,
   input wire logic pull_dn_i,
   // Board and peripheral control
   input wire logic [7:0] ext_lvl_i,
   input wire logic [7:0] ext_drv_i,
   input wire logic [7:0] alt_pat_i,
   input wire logic alt_run_i,
   // Pin levels and peripheral outputs
   output logic [7:0] pin_lvl_o,
   output logic [7:0] alt_a_o,
   output logic [7:0] alt_b_o,
   output logic [7:0] alt_oe_o
);
   logic [7:0] last_q;
   always_ff @(posedge clock_i) last_q <= pin_lvl_o;
   // Undriven pins flip each cycle so a stale level is never trusted
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_i[i]) pin_lvl_o[i] = pin_o_i[i];
         else if (ext_drv_i[i]) pin_lvl_o[i] = ext_lvl_i[i];
         else if (i == 5 && pull_dn_i) pin_lvl_o[i] = 1'b0;
         else pin_lvl_o[i] = ~last_q[i];
      end
   end
   // Peripheral drives only once software has enabled it
   assign alt_a_o = alt_pat_i;
   assign alt_b_o = ~alt_pat_i;
   assign alt_oe_o = alt_run_i ? 8'hFF : 8'h00;
endmodule : ppfm_pin_model

// [sim/ppfm_port_mux_chk.sv]
`timescale 1ns/100ps
module ppfm_port_mux_chk (
   // Clock and resets
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic wdt_rst_i,
   input wire logic clkmon_rst_i,
   input wire logic lvd_rst_i,
   // Watched ports
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [7:0] pin_i,
   input wire logic [7:0] alt_in_o,
   input wire logic dbg_pull_dn_en_o,
   input wire logic debug_reset_in_o,
   input wire logic debug_pins_en_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   chk_ready_answer: assert property (psel_i && !penable_i |=> pready_o)
      else $error("ready missing in access cycle");
   chk_ready_pulse: assert property (pready_o |-> penable_i ##1 !pready_o)
      else $error("ready not a single access pulse");
   chk_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   chk_alt_gate:
      assert property ((alt_in_o & ~$past(pin_i)) == 8'h00)
      else $error("alternate input high on low pin");
   chk_dbg_level:
      assert property (debug_reset_in_o |-> $past(pin_i[5]))
      else $error("debug reset input without high pin");
   chk_dbg_enter:
      assert property (debug_reset_in_o |-> ##[0:2] debug_pins_en_o)
      else $error("debug mode not entered");
   chk_pull_reset:
      assert property ($rose(arst_n_i) |-> dbg_pull_dn_en_o)
      else $error("pull-down off after pin reset");
   chk_pull_keep:
      assert property (wdt_rst_i || clkmon_rst_i || lvd_rst_i |=>
         $stable(dbg_pull_dn_en_o)) else $error("internal reset moved pull");
endmodule : ppfm_port_mux_chk

bind ppfm_port_mux ppfm_port_mux_chk ppfm_port_mux_chk_i (
   .clock_i, .arst_n_i, .wdt_rst_i, .clkmon_rst_i, .lvd_rst_i, .psel_i,
   .penable_i, .pready_o, .pslverr_o, .pin_i, .alt_in_o, .dbg_pull_dn_en_o,
   .debug_reset_in_o, .debug_pins_en_o);

// [sim/test_port_pin_function_mux.sv]
`timescale 1ns/100ps
module test_port_pin_function_mux;
   logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, alt_run = 1'b0;
   logic [2:0] irst = 3'h0;
   logic [7:0] paddr = 8'h00, ext_lvl = 8'h00, ext_drv = 8'hFF;
   logic [7:0] alt_pat = 8'h0A;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, pull, nmi, dbg_in, dbg_en, irq;
   logic [7:0] pin_lvl, pin_o, pin_oe, alt_a, alt_b, alt_oe, alt_in;
   logic [31:0] prdata;
   int n_fail = 0;
   int check_count = 0;
   int nmi_cnt = 0;

   ppfm_port_mux ppfm_port_mux_i (.clock_i(clk), .arst_n_i(arst_n),
      .wdt_rst_i(irst[0]), .clkmon_rst_i(irst[1]), .lvd_rst_i(irst[2]),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .pin_i(pin_lvl),
      .pin_o(pin_o), .pin_oe_o(pin_oe), .dbg_pull_dn_en_o(pull),
      .alt_a_out_i(alt_a), .alt_b_out_i(alt_b), .alt_oe_i(alt_oe),
      .alt_in_o(alt_in), .nmi_req_o(nmi), .debug_reset_in_o(dbg_in),
      .debug_pins_en_o(dbg_en), .irq_o(irq));
   ppfm_pin_model ppfm_pin_model_i (.clock_i(clk), .pin_o_i(pin_o),
      .pin_oe_i(pin_oe), .pull_dn_i(pull), .ext_lvl_i(ext_lvl),
      .ext_drv_i(ext_drv), .alt_pat_i(alt_pat), .alt_run_i(alt_run),
      .pin_lvl_o(pin_lvl), .alt_a_o(alt_a), .alt_b_o(alt_b),
      .alt_oe_o(alt_oe));

   always #2 clk = ~clk;
   always @(posedge clk) if (nmi === 1'b1) nmi_cnt++;

   function automatic logic [7:0] port_read(input logic [7:0] d, e, v);
      return (d & e) | (~d & v);
   endfunction : port_read
   task automatic cmp8(input string nm, input logic [7:0] x, y);
      check_count++;
      if (y !== x) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, x, y);
      end
   endtask : cmp8
   task automatic cmp1(input string nm, input logic x, y);
      cmp8(nm, {7'h0, x}, {7'h0, y});
   endtask : cmp1
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r,
                      output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_fail++;
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, x,
                     input logic xe = 1'b0);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      cmp8(nm, x, r[7:0]);
      cmp1({nm, " upper"}, 1'b0, |r[31:8]);
      cmp1({nm, " err"}, xe, e);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic ipulse(input int k);
      @(posedge clk) irst[k] <= 1'b1;
      @(posedge clk) irst[k] <= 1'b0;
      tick(2);
   endtask : ipulse
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test

   initial begin
      #(4 * 20000);
      n_fail++;
      stop_test();
   end

   initial begin
      logic [7:0] v, d, e, m;
      int c0;
      void'($urandom(86296));
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      tick(1);
      cmp1("pull", 1'b1, pull);
      rd("dir", ppfm_pkg::OFS_DIR, 8'hFF);
      rd("dbg", ppfm_pkg::OFS_DBG, 8'h01);
      rd("hole", 8'h30, 8'h00, 1'b1);
      wr(ppfm_pkg::OFS_DIR, 32'h0);
      wr(ppfm_pkg::OFS_DATA, 32'hFF);
      @(posedge clk) ext_lvl <= 8'h20;
      tick(4);
      cmp1("oe5", 1'b0, pin_oe[5]);
      cmp1("dbg in", 1'b1, dbg_in);
      cmp1("dbg pins", 1'b1, dbg_en);
      rd("dbg status", ppfm_pkg::OFS_IRQ_STAT, 8'h02);
      for (int k = 0; k < 3; k++) begin
         ipulse(k);
         cmp1("pull kept", 1'b1, pull);
         rd("dbg kept", ppfm_pkg::OFS_DBG, 8'h01);
         rd("dir cleared", ppfm_pkg::OFS_DIR, 8'hFF);
      end
      @(posedge clk) ext_drv <= 8'hDF;
      tick(2);
      cmp1("pulled low", 1'b0, pin_lvl[5]);
      wr(ppfm_pkg::OFS_DBG, 32'h0);
      tick(2);
      cmp1("pull off", 1'b0, pull);
      ipulse(0);
      cmp1("pull stays", 1'b0, pull);
      rd("dbg stays", ppfm_pkg::OFS_DBG, 8'h00);
      @(posedge clk) ext_drv <= 8'hFF;
      ext_lvl <= 8'h00;
      @(posedge clk) arst_n <= 1'b0;
      @(posedge clk) arst_n <= 1'b1;
      tick(1);
      cmp1("pull again", 1'b1, pull);
      rd("dbg again", ppfm_pkg::OFS_DBG, 8'h01);
      wr(ppfm_pkg::OFS_DBG, 32'h0);
      $display("test debug pin finished");
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom);
         d = 8'($urandom);
         e = 8'($urandom);
         m = 8'($urandom);
         @(posedge clk) ext_lvl <= e;
         wr(ppfm_pkg::OFS_MODE, {24'h0, m});
         wr(ppfm_pkg::OFS_DATA, {24'h0, v});
         wr(ppfm_pkg::OFS_MODE, 32'h0);
         wr(ppfm_pkg::OFS_DIR, {24'h0, d});
         tick(2);
         rd("data", ppfm_pkg::OFS_DATA, port_read(d, e, v));
         cmp8("oe", ~d, pin_oe);
         cmp8("out", v & ~d, pin_o & ~d);
      end
      wr(ppfm_pkg::OFS_ODRN, 32'hFF);
      wr(ppfm_pkg::OFS_DIR, 32'h0);
      wr(ppfm_pkg::OFS_DATA, 32'hAA);
      tick(2);
      cmp8("od oe", 8'h55, pin_oe);
      wr(ppfm_pkg::OFS_DIR, 32'hFF);
      #1 cmp8("oe held", 8'h55, pin_oe);
      tick(1);
      cmp8("od input", 8'h00, pin_oe);
      wr(ppfm_pkg::OFS_ODRN, 32'h0);
      @(posedge clk) ext_lvl <= 8'hFF;
      wr(ppfm_pkg::OFS_DATA, 32'h0);
      wr(ppfm_pkg::OFS_DIR, 32'hFE);
      tick(2);
      wr(ppfm_pkg::OFS_BITOP, 32'h100);
      wr(ppfm_pkg::OFS_DIR, 32'h0);
      tick(2);
      cmp8("bit op latch", 8'hFF, pin_o);
      wr(ppfm_pkg::OFS_DATA, 32'h01);
      rd("rewrite", ppfm_pkg::OFS_DATA, 8'h01);
      $display("test port data finished");
      wr(ppfm_pkg::OFS_DIR, 32'hFF);
      wr(ppfm_pkg::OFS_MODE, 32'h0A);
      @(posedge clk) alt_run <= 1'b1;
      tick(2);
      cmp1("serial out", alt_pat[1], pin_o[1]);
      cmp1("serial oe", 1'b1, pin_oe[1]);
      cmp1("gate on", 1'b1, alt_in[3]);
      wr(ppfm_pkg::OFS_FSEL, 32'h2);
      wr(ppfm_pkg::OFS_ODRN, 32'h2);
      tick(2);
      cmp1("clock out", ~alt_pat[1], pin_o[1]);
      cmp1("clock low oe", 1'b1, pin_oe[1]);
      @(posedge clk) alt_pat <= 8'h08;
      tick(2);
      cmp1("clock high oe", 1'b0, pin_oe[1]);
      @(posedge clk) alt_run <= 1'b0;
      wr(ppfm_pkg::OFS_MODE, 32'h0);
      tick(2);
      cmp1("gate off", 1'b0, alt_in[3]);
      $display("test alternate finished");
      wr(ppfm_pkg::OFS_IRQ_MASK, 32'h1);
      wr(ppfm_pkg::OFS_EDGE, 32'h1);
      c0 = nmi_cnt;
      wr(ppfm_pkg::OFS_MODE, 32'h4);
      tick(4);
      cmp8("rise edge", 8'(c0 + 1), 8'(nmi_cnt));
      cmp1("irq", 1'b1, irq);
      rd("status", ppfm_pkg::OFS_IRQ_STAT, 8'h01);
      wr(ppfm_pkg::OFS_IRQ_STAT, 32'h1);
      tick(1);
      cmp1("irq cleared", 1'b0, irq);
      wr(ppfm_pkg::OFS_EDGE, 32'h2);
      wr(ppfm_pkg::OFS_IRQ_MASK, 32'h0);
      wr(ppfm_pkg::OFS_MODE, 32'h0);
      tick(4);
      cmp8("fall edge", 8'(c0 + 2), 8'(nmi_cnt));
      cmp1("irq masked", 1'b0, irq);
      wr(ppfm_pkg::OFS_EDGE, 32'h0);
      wr(ppfm_pkg::OFS_MODE, 32'h4);
      wr(ppfm_pkg::OFS_EDGE, 32'h1);
      wr(ppfm_pkg::OFS_EDGE, 32'h0);
      wr(ppfm_pkg::OFS_MODE, 32'h0);
      tick(4);
      cmp8("no edge", 8'(c0 + 2), 8'(nmi_cnt));
      $display("test edge finished");
      stop_test();
   end
endmodule : test_port_pin_function_mux
